// file: inc/status_image_pkg.sv
// package: layout constants and carriers for the status image builder
package status_image_pkg;

  localparam int N_EXP            = 12;
  localparam int STATE_WORD_BITS  = 16;
  localparam int STATE_BYTES      = 4;
  localparam int CRC_SET_BYTES    = 32;
  localparam int DIAG_SET_BYTES   = 60;
  localparam int MAIN_DIAG_BYTES  = 12;
  localparam int EXP_DIAG_BYTES   = 4;
  localparam int PROJ_CRC_BYTE    = 0;
  localparam int SYS_CRC_BYTE     = 4;
  localparam int CRC_RSVD_BYTE    = 8;
  // state word bit positions
  localparam int BIT_MAIN         = 0;
  localparam int BIT_GW1          = 13;
  localparam int BIT_GW2          = 14;
  localparam int BIT_RSVD         = 15;
  // main controller diagnostic layout
  localparam int MD_STATE_BYTE    = 0;
  localparam int MD_PULSE_BYTE    = 2;
  localparam int MD_DUAL_BYTE     = 5;
  localparam int MD_RSVD7_BYTE    = 7;
  localparam int MD_STUCK_BYTE    = 8;
  localparam int MD_RSVD10_BYTE   = 10;
  // axi-lite register map (byte offsets)
  localparam logic [7:0] REG_STATUS  = 8'h00;
  localparam logic [7:0] REG_MASK    = 8'h04;
  localparam logic [7:0] REG_CTRL    = 8'h08;
  localparam logic [7:0] REG_STATE   = 8'h0C;
  localparam logic [7:0] REG_PCRC    = 8'h10;
  localparam logic [7:0] REG_SCRC    = 8'h14;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
  localparam logic [7:0]  BYTE_ONES  = 8'hFF;
  // interrupt status bits
  localparam int IRQ_REFRESH      = 0;
  localparam int IRQ_COMM_ERR     = 1;
  localparam int IRQ_BITS         = 2;

  typedef struct packed {
    logic [N_EXP-1:0]      present;   // expansion slot populated
    logic [N_EXP+2:0]      in_ok;     // main, exp 1..12, gw1, gw2
    logic [N_EXP+2:0]      out_ok;
    logic [N_EXP*8-1:0]    in_val;    // pre-evaluated element states
    logic [N_EXP*8-1:0]    in_dual;   // 1 per bit pair: two-channel input
    logic [N_EXP*8-1:0]    in_pair_ok;// health per bit pair (even pos used)
    logic [(N_EXP+1)*8-1:0] out_cmd;  // main + exp control commands
    logic [(N_EXP+1)*8-1:0] out_dual;
  } module_state_s;

  typedef struct packed {
    logic [15:0]              state;
    logic [39:0]              pulse_dual; // bytes 2..6
    logic [15:0]              stuck;
    logic [N_EXP*32-1:0]      exp_status; // 32-bit word per module
  } diag_src_s;

endpackage : status_image_pkg

// file: rtl/module_status_image_builder.sv
// module: builds state, value, check-value and diagnostic images
`timescale 1ns/100ps
module module_status_image_builder
  import status_image_pkg::*;
(
  // clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_reset_n,
  // module states from the system
  input  wire status_image_pkg::module_state_s i_mods,
  input  wire status_image_pkg::diag_src_s     i_diag,
  input  wire logic [31:0]                   i_project_crc,
  input  wire logic [31:0]                   i_system_crc,
  // network transmit side
  input  wire logic                          i_tx_start,
  input  wire logic                          i_comm_err,
  output logic                               o_comm_ok,
  output logic [STATE_BYTES*8-1:0]           o_state_image,
  output logic [N_EXP*8-1:0]                 o_in_values,
  output logic [(N_EXP+1)*8-1:0]             o_out_values,
  output logic [CRC_SET_BYTES*8-1:0]         o_crc_image,
  output logic [DIAG_SET_BYTES*8-1:0]        o_diag_image,
  output logic                               o_image_valid,
  // axi4-lite slave
  input  wire logic [7:0]                    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [7:0]                    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // interrupt
  output logic                               o_irq
);

  logic [STATE_BYTES*8-1:0]    state_calc;
  logic [N_EXP*8-1:0]          in_calc;
  logic [(N_EXP+1)*8-1:0]      out_calc;
  logic [CRC_SET_BYTES*8-1:0]  crc_calc;
  logic [DIAG_SET_BYTES*8-1:0] diag_calc;

  // summary words: ok inputs map straight to bits 0..14, bit 15 reserved
  always_comb
  begin
    state_calc = '0;
    state_calc[BIT_GW2:BIT_MAIN] = i_mods.in_ok;
    state_calc[BIT_RSVD] = 1'b0;
    state_calc[16+BIT_GW2:16+BIT_MAIN] = i_mods.out_ok;
    state_calc[16+BIT_RSVD] = 1'b0;
  end

  // per-bit-pair encoding of the value bytes
  genvar gi;
  generate
    for (gi = 0; gi < N_EXP*4; gi++)
    begin : g_in_pair
      always_comb
      begin
        in_calc[2*gi] = i_mods.in_val[2*gi];
        in_calc[2*gi+1] = i_mods.in_dual[2*gi]
                          ? i_mods.in_pair_ok[2*gi]
                          : i_mods.in_val[2*gi+1];
      end
    end
    for (gi = 0; gi < (N_EXP+1)*4; gi++)
    begin : g_out_pair
      always_comb
      begin
        out_calc[2*gi] = i_mods.out_cmd[2*gi];
        out_calc[2*gi+1] = i_mods.out_dual[2*gi]
                           ? 1'b0
                           : i_mods.out_cmd[2*gi+1];
      end
    end
  endgenerate

  // check-value set: big-endian crcs, reserved tail zero
  always_comb
  begin
    crc_calc = '0;
    for (int b = 0; b < 4; b++)
    begin
      crc_calc[(PROJ_CRC_BYTE+b)*8 +: 8] =
        i_project_crc[(3-b)*8 +: 8];
      crc_calc[(SYS_CRC_BYTE+b)*8 +: 8] =
        i_system_crc[(3-b)*8 +: 8];
    end
  end

  // diagnostic set: byte k of image sits at bit k*8 (first byte sent lowest)
  always_comb
  begin
    diag_calc = '0;
    diag_calc[MD_STATE_BYTE*8 +: 16] = i_diag.state;
    diag_calc[MD_PULSE_BYTE*8 +: 40] = i_diag.pulse_dual;
    diag_calc[MD_RSVD7_BYTE*8 +: 8] = BYTE_ONES;
    diag_calc[MD_STUCK_BYTE*8 +: 16] = i_diag.stuck;
    diag_calc[MD_RSVD10_BYTE*8 +: 16] = {BYTE_ONES, BYTE_ONES};
    for (int m = 0; m < N_EXP; m++)
    begin
      // little-endian: word lsb goes out as the module's first byte
      diag_calc[(MAIN_DIAG_BYTES+EXP_DIAG_BYTES*m)*8 +: 32] =
        i_mods.present[m] ? i_diag.exp_status[m*32 +: 32]
                          : {4{BYTE_ONES}};
    end
  end

  // image registers
  logic [STATE_BYTES*8-1:0]    state_reg, state_next;
  logic [N_EXP*8-1:0]          in_reg, in_next;
  logic [(N_EXP+1)*8-1:0]      out_reg, out_next;
  logic [CRC_SET_BYTES*8-1:0]  crc_reg, crc_next;
  logic [DIAG_SET_BYTES*8-1:0] diag_reg, diag_next;
  logic                        ok_reg, ok_next;
  logic                        valid_reg, valid_next;
  logic                        hold_reg, hold_next;
  logic [IRQ_BITS-1:0]         stat_reg, stat_next;
  logic [IRQ_BITS-1:0]         mask_reg, mask_next;
  logic                        refresh_evt;

  always_comb
  begin
    state_next = state_reg;
    in_next = in_reg;
    out_next = out_reg;
    crc_next = crc_reg;
    diag_next = diag_reg;
    ok_next = ok_reg;
    valid_next = 1'b0;
    refresh_evt = 1'b0;
    if (i_comm_err)
    begin
      state_next = '0;
      in_next = '0;
      out_next = '0;
      crc_next = '0;
      diag_next = '0;
      ok_next = 1'b0;
    end
    else if (i_tx_start && !hold_reg)
    begin
      state_next = state_calc;
      in_next = in_calc;
      out_next = out_calc;
      crc_next = crc_calc;
      diag_next = diag_calc;
      ok_next = 1'b1;
      valid_next = 1'b1;
      refresh_evt = 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      state_reg <= '0;
      in_reg <= '0;
      out_reg <= '0;
      crc_reg <= '0;
      diag_reg <= '0;
      ok_reg <= 1'b0;
      valid_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      in_reg <= in_next;
      out_reg <= out_next;
      crc_reg <= crc_next;
      diag_reg <= diag_next;
      ok_reg <= ok_next;
      valid_reg <= valid_next;
    end
  end

  assign o_state_image = state_reg;
  assign o_in_values = in_reg;
  assign o_out_values = out_reg;
  assign o_crc_image = crc_reg;
  assign o_diag_image = diag_reg;
  assign o_comm_ok = ok_reg;
  assign o_image_valid = valid_reg;

  // axi4-lite slave: one write and one read at a time
  logic       aw_reg, aw_next, w_reg, w_next, b_reg, b_next;
  logic [7:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next;
  logic       bres_reg, bres_next;
  logic       r_reg, r_next, rres_reg, rres_next;
  logic [31:0] rd_reg, rd_next;

  assign s_axi_awready = !aw_reg && !b_reg;
  assign s_axi_wready = !w_reg && !b_reg;
  assign s_axi_bvalid = b_reg;
  assign s_axi_bresp = bres_reg ? RESP_SLVERR : RESP_OKAY;
  assign s_axi_arready = !r_reg;
  assign s_axi_rvalid = r_reg;
  assign s_axi_rdata = rd_reg;
  assign s_axi_rresp = rres_reg ? RESP_SLVERR : RESP_OKAY;

  always_comb
  begin
    aw_next = aw_reg;
    w_next = w_reg;
    b_next = b_reg;
    awa_next = awa_reg;
    wd_next = wd_reg;
    bres_next = bres_reg;
    mask_next = mask_reg;
    hold_next = hold_reg;
    stat_next = stat_reg;
    r_next = r_reg;
    rres_next = rres_reg;
    rd_next = rd_reg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_next = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_next = 1'b1;
      wd_next = s_axi_wdata;
    end
    if (b_reg && s_axi_bready)
      b_next = 1'b0;
    if (aw_reg && w_reg)
    begin
      aw_next = 1'b0;
      w_next = 1'b0;
      b_next = 1'b1;
      bres_next = 1'b0;
      // crc and state words are read-only images
      unique case ({awa_reg[7:2], 2'b00})
        REG_STATUS: stat_next = stat_reg & ~wd_reg[IRQ_BITS-1:0];
        REG_MASK:   mask_next = wd_reg[IRQ_BITS-1:0];
        REG_CTRL:   hold_next = wd_reg[0];
        default:    bres_next = 1'b1;
      endcase
    end
    // hardware set wins over software clear
    if (refresh_evt)
      stat_next[IRQ_REFRESH] = 1'b1;
    if (i_comm_err)
      stat_next[IRQ_COMM_ERR] = 1'b1;
    if (r_reg && s_axi_rready)
      r_next = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      r_next = 1'b1;
      rres_next = 1'b0;
      unique case ({s_axi_araddr[7:2], 2'b00})
        REG_STATUS: rd_next = {30'h000_0000, stat_reg};
        REG_MASK:   rd_next = {30'h000_0000, mask_reg};
        REG_CTRL:   rd_next = {30'h000_0000, ok_reg, hold_reg};
        REG_STATE:  rd_next = state_reg;
        REG_PCRC:   rd_next = crc_reg[31:0];
        REG_SCRC:   rd_next = crc_reg[63:32];
        default:
        begin
          rd_next = RST_ZERO;
          rres_next = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      b_reg <= 1'b0;
      awa_reg <= '0;
      wd_reg <= RST_ZERO;
      bres_reg <= 1'b0;
      mask_reg <= '0;
      hold_reg <= 1'b0;
      stat_reg <= '0;
      r_reg <= 1'b0;
      rres_reg <= 1'b0;
      rd_reg <= RST_ZERO;
    end
    else
    begin
      aw_reg <= aw_next;
      w_reg <= w_next;
      b_reg <= b_next;
      awa_reg <= awa_next;
      wd_reg <= wd_next;
      bres_reg <= bres_next;
      mask_reg <= mask_next;
      hold_reg <= hold_next;
      stat_reg <= stat_next;
      r_reg <= r_next;
      rres_reg <= rres_next;
      rd_reg <= rd_next;
    end
  end

  assign o_irq = |(stat_reg & mask_reg);

  // assertions
  property p_comm_clear;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_comm_err |=> (state_reg == '0) && !o_comm_ok && (diag_reg == '0);
  endproperty
  a_comm_clear: assert property (p_comm_clear)
    else $error("comm error did not clear images");

  property p_refresh;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_tx_start && !hold_reg && !i_comm_err) |=>
      o_image_valid && (state_reg == $past(state_calc));
  endproperty
  a_refresh: assert property (p_refresh)
    else $error("state image not refreshed on transmit");

  property p_rsvd_state;
    @(posedge i_clk) disable iff (!i_reset_n)
    !state_reg[BIT_RSVD] && !state_reg[16+BIT_RSVD];
  endproperty
  a_rsvd_state: assert property (p_rsvd_state)
    else $error("reserved state bit set");

  property p_rsvd_diag;
    @(posedge i_clk) disable iff (!i_reset_n)
    o_image_valid |-> (diag_reg[MD_RSVD7_BYTE*8 +: 8] == BYTE_ONES)
      && (diag_reg[MD_RSVD10_BYTE*8 +: 16] == 16'hFFFF);
  endproperty
  a_rsvd_diag: assert property (p_rsvd_diag)
    else $error("reserved diagnostic byte not all ones");

  property p_crc_order;
    @(posedge i_clk) disable iff (!i_reset_n)
    o_image_valid |-> (crc_reg[7:0] == $past(i_project_crc[31:24]))
      && (crc_reg[CRC_RSVD_BYTE*8 +: 8] == 8'h00);
  endproperty
  a_crc_order: assert property (p_crc_order)
    else $error("project crc byte order wrong");

  property p_absent;
    @(posedge i_clk) disable iff (!i_reset_n)
    (o_image_valid && !$past(i_mods.present[0])) |->
      diag_reg[MAIN_DIAG_BYTES*8 +: 32] == 32'hFFFF_FFFF;
  endproperty
  a_absent: assert property (p_absent)
    else $error("missing module not all ones");

  property p_out_odd;
    @(posedge i_clk) disable iff (!i_reset_n)
    (o_image_valid && $past(i_mods.out_dual[0])) |-> !out_reg[1];
  endproperty
  a_out_odd: assert property (p_out_odd)
    else $error("two-channel output odd bit not low");

  property p_in_odd;
    @(posedge i_clk) disable iff (!i_reset_n)
    (o_image_valid && $past(i_mods.in_dual[0])) |->
      in_reg[1] == $past(i_mods.in_pair_ok[0]);
  endproperty
  a_in_odd: assert property (p_in_odd)
    else $error("two-channel input health bit wrong");

endmodule : module_status_image_builder

// file: verif/network_master_model.sv
// network master model: requests transmissions and captures sent images
`timescale 1ns/100ps
module network_master_model
  import status_image_pkg::*;
(
  // clock and bench request
  input  wire logic                                       i_clk,
  input  wire logic                                       i_req,
  // transmit start to the block
  output logic                                            o_tx_start,
  // images offered by the block
  input  wire logic                                       i_image_valid,
  input  wire logic [status_image_pkg::CRC_SET_BYTES*8-1:0]  i_crc,
  input  wire logic [status_image_pkg::DIAG_SET_BYTES*8-1:0] i_diag,
  // captured copies for the bench
  output logic [status_image_pkg::CRC_SET_BYTES*8-1:0]    o_crc_cap,
  output logic [status_image_pkg::DIAG_SET_BYTES*8-1:0]   o_diag_cap,
  output logic [7:0]                                      o_cap_count
);
  initial
  begin
    o_tx_start  = 1'b0;
    o_crc_cap   = '0;
    o_diag_cap  = '0;
    o_cap_count = 8'h00;
  end
  always @(posedge i_clk)
  begin
    o_tx_start <= i_req;
    // the check-value set is only read, never written back
    if (i_image_valid)
    begin
      o_crc_cap   <= i_crc;
      o_diag_cap  <= i_diag;
      o_cap_count <= o_cap_count + 8'h01;
    end
  end
endmodule : network_master_model

// file: verif/module_status_image_builder_tb_top.sv
// testbench: image builder driven through its images and axi-lite slave
`timescale 1ns/100ps
module module_status_image_builder_tb_top;
  import status_image_pkg::*;
  logic          i_clk, i_reset_n, comm_err, req, tx_start, comm_ok;
  module_state_s mods;
  diag_src_s     diag;
  logic [31:0]   pcrc, scrc, wdata, rdata;
  logic [31:0]   st_img;
  logic [95:0]   in_v;
  logic [103:0]  out_v;
  logic [255:0]  crc_img, crc_cap;
  logic [479:0]  diag_img, diag_cap;
  logic [7:0]    awaddr, araddr, cap_count;
  logic          awvalid, awready, wvalid, wready, bvalid, bready;
  logic          arvalid, arready, rvalid, rready, img_valid, irq;
  logic [1:0]    bresp, rresp, resp;
  logic          got;
  int            err_count, check_count;

  initial i_clk = 1'b0;
  always #50 i_clk = ~i_clk;

  module_status_image_builder module_status_image_builder_inst (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_mods(mods), .i_diag(diag),
    .i_project_crc(pcrc), .i_system_crc(scrc), .i_tx_start(tx_start),
    .i_comm_err(comm_err), .o_comm_ok(comm_ok), .o_state_image(st_img),
    .o_in_values(in_v), .o_out_values(out_v), .o_crc_image(crc_img),
    .o_diag_image(diag_img), .o_image_valid(img_valid),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .o_irq(irq));

  network_master_model network_master_model_inst (
    .i_clk(i_clk), .i_req(req), .o_tx_start(tx_start),
    .i_image_valid(img_valid), .i_crc(crc_img), .i_diag(diag_img),
    .o_crc_cap(crc_cap), .o_diag_cap(diag_cap), .o_cap_count(cap_count));

  task test_done;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [479:0] e,
                     input logic [479:0] g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge i_clk);
    resp = 2'bxx;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (50)
    begin
      @(posedge i_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        resp = bresp;
        bready <= 1'b0;
        done = 1'b1;
        break;
      end
    end
    // a write that never answers is a mismatch, not a silent pass
    if (!done)
    begin
      err_count++;
      $display("CHECK FAILED write %h exp bvalid got none", a);
    end
  endtask : axi_wr

  // read and compare data and response together
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    logic [33:0] g;
    g = 'x;
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (50)
    begin
      @(posedge i_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        g = {rresp, rdata};
        rready <= 1'b0;
        break;
      end
    end
    check_count++;
    if (g !== {er, e})
    begin
      err_count++;
      $display("CHECK FAILED read %h exp %h got %h", a, {er, e}, g);
    end
  endtask : chk_rd

  function automatic logic [95:0] f_in();
    logic [95:0] v;
    v = mods.in_val;
    for (int k = 0; k < 96; k += 2)
      if (mods.in_dual[k]) v[k+1] = mods.in_pair_ok[k];
    return v;
  endfunction : f_in

  function automatic logic [103:0] f_out();
    logic [103:0] v;
    v = mods.out_cmd;
    for (int k = 0; k < 104; k += 2)
      if (mods.out_dual[k]) v[k+1] = 1'b0;
    return v;
  endfunction : f_out

  function automatic logic [479:0] f_diag();
    logic [479:0] v;
    v = '0;
    v[95:0] = {16'hFFFF, diag.stuck, 8'hFF, diag.pulse_dual, diag.state};
    for (int n = 0; n < N_EXP; n++)
      v[96+32*n +: 32] = mods.present[n] ? diag.exp_status[32*n +: 32]
                                         : 32'hFFFF_FFFF;
    return v;
  endfunction : f_diag

  task automatic set_pat(input logic [7:0] s);
    @(posedge i_clk);
    // odd patterns leave modules 1 and 3 out, even ones module 12
    mods.present <= s[0] ? 12'hFFA : 12'h7FF;
    mods.in_ok <= {s[6:0], s};
    mods.out_ok <= ~{s[6:0], s};
    mods.in_val <= {12{s}};
    mods.in_dual <= s[0] ? {12{8'h33}} : {12{8'hCC}};
    mods.in_pair_ok <= {12{~s}};
    mods.out_cmd <= {13{s}};
    mods.out_dual <= s[0] ? {13{8'hC3}} : {13{8'h3C}};
    diag <= {s, ~s, {5{s}}, ~s, s, {12{s, ~s, 8'h5A, s}}};
    pcrc <= {4{s}} ^ 32'h0123_4567;
    scrc <= {4{~s}} ^ 32'h89AB_CDEF;
  endtask : set_pat

  task automatic do_tx(output logic g);
    logic [7:0] c;
    c = cap_count;
    g = 1'b0;
    @(posedge i_clk);
    req <= 1'b1;
    @(posedge i_clk);
    req <= 1'b0;
    repeat (8)
    begin
      @(posedge i_clk);
      if (cap_count != c)
      begin
        g = 1'b1;
        break;
      end
    end
  endtask : do_tx

  task automatic chk_all;
    logic [31:0] pc, sc;
    pc = {<<8{pcrc}};
    sc = {<<8{scrc}};
    chk("valid pulse", 0, img_valid);
    chk("state", {1'b0, mods.out_ok, 1'b0, mods.in_ok}, st_img);
    chk("in values", f_in(), in_v);
    chk("out values", f_out(), out_v);
    chk("crc set", {192'h0, sc, pc}, crc_cap);
    chk("diag set", f_diag(), diag_cap);
    chk("comm ok", 1, comm_ok);
    chk("captured", 1, got);
    chk_rd(REG_PCRC, pc, RESP_OKAY);
    chk_rd(REG_SCRC, sc, RESP_OKAY);
  endtask : chk_all

  initial
  begin
    #2000000;
    err_count++;
    test_done;
  end

  initial
  begin
    {mods, diag, pcrc, scrc, comm_err, req} = '0;
    {awaddr, wdata, awvalid, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    err_count = 0;
    check_count = 0;
    i_reset_n = 1'b0;
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    chk("reset diag", 0, diag_img);
    chk("reset irq", 0, irq);
    chk_rd(REG_STATUS, RST_ZERO, RESP_OKAY);
    set_pat(8'hA5);
    do_tx(got);
    chk_all;
    chk_rd(REG_STATE, {1'b0, mods.out_ok, 1'b0, mods.in_ok}, RESP_OKAY);
    chk_rd(REG_CTRL, 32'h0000_0002, RESP_OKAY);
    // back to back refresh with new module states
    set_pat(8'h3C);
    do_tx(got);
    chk_all;
    set_pat(8'h5A);
    do_tx(got);
    chk_all;
    chk_rd(REG_STATUS, 32'h0000_0001, RESP_OKAY);
    chk("irq masked", 0, irq);
    axi_wr(REG_MASK, 32'h0000_0001);
    chk_rd(REG_MASK, 32'h0000_0001, RESP_OKAY);
    @(posedge i_clk);
    chk("irq on", 1, irq);
    axi_wr(REG_STATUS, 32'h0000_0001);
    @(posedge i_clk);
    chk("irq cleared", 0, irq);
    @(posedge i_clk);
    comm_err <= 1'b1;
    @(posedge i_clk);
    comm_err <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk("err state", 0, st_img);
    chk("err diag", 0, diag_img);
    chk("err crc", 0, crc_img);
    chk("err comm ok", 0, comm_ok);
    chk_rd(REG_STATUS, 32'h0000_0002, RESP_OKAY);
    // hold blocks a refresh request
    axi_wr(REG_CTRL, 32'h0000_0001);
    do_tx(got);
    chk("held", 0, got);
    chk("held diag", 0, diag_img);
    axi_wr(REG_CTRL, RST_ZERO);
    axi_wr(REG_STATE, 32'hFFFF_FFFF);
    chk("ro write", RESP_SLVERR, resp);
    axi_wr(8'h40, 32'h0000_0001);
    chk("unmapped write", RESP_SLVERR, resp);
    chk_rd(8'h40, RST_ZERO, RESP_SLVERR);
    test_done;
  end
endmodule : module_status_image_builder_tb_top
